/* File: common/ira_pkg.sv */
// shared constants for the i2c register access target
package ira_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;      // arbitrary default target address
    localparam logic [7:0] HS_CODE_MASK = 8'hf8;      // upper five bits fixed
    localparam logic [7:0] HS_CODE_VAL = 8'h08;       // 0b0000_1xxx
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam int BIT_LAST = 7;
    localparam logic [2:0] BIT_CNT_RESET = 3'h7;
    localparam int REG_DEPTH = 256;
endpackage

/* File: hdl/ira_sync.sv */
// two flip-flop synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module ira_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // level
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/ira_slave.sv */
// i2c register access target with register store and filter mode control
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - write: address low bit, then pointer, acknowledged
// - ack write data, commit on sda rise
// - sequential writes store to consecutive registers
// - stop restores slow filters; sr keeps them
// - read: pointer write, sr, read address acked
// - drive eight bits msb first from pointer
// - host ack requests next register byte
// - stop keeps the register pointer
// - master code gets nack, fast filters
// - fast mode survives sr, ends at stop
// - any pointer value is acknowledged
// - clock line never held low
// - general call and other addresses not acked
module ira_slave (
    // core clock domain
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // link clock domain (scl)
    input wire logic scl_clk_i,
    // sda pin, oe low while driving low
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // scl pin, never driven
    output logic scl_o,
    output logic scl_oe_n_o,
    // configuration
    input wire logic [6:0] dev_addr_i,
    // status toward the core
    output logic hs_mode_o,
    output logic [7:0] reg_ptr_o,
    output logic [7:0] wr_data_o,
    output logic [7:0] wr_addr_o,
    output logic wr_commit_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_RACK}
        ira_state_t;

    ////////////////////////////////////////////////////////////////////////
    // start and stop detection, link clock level sampled on sda edges
    // start/stop are seen on sda edges while scl high; scl is stopped then, so
    // they are caught with sda as a clock and scl as data.
    logic start_tgl_q;
    logic stop_tgl_q;
    always_ff @(negedge sda_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_tgl_q <= 1'b0;
        end else if (scl_clk_i) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end
    always_ff @(posedge sda_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_tgl_q <= 1'b0;
        end else if (scl_clk_i) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link side bit engine on scl
    ira_state_t state_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic ack_cycle_q;
    logic ack_drive_q;
    logic tx_bit_q;
    logic tx_en_q;
    logic hs_tgl_q;
    logic wr_tgl_q;
    logic [7:0] wr_data_q;
    logic [7:0] wr_addr_q;
    logic start_seen_q;
    logic stop_seen_q;
    localparam int REG_DEPTH = ira_pkg::REG_DEPTH;
    logic [7:0] regs_q [REG_DEPTH-1:0];
    logic [7:0] rx_byte;
    logic addr_match;
    logic hs_code;
    logic new_start;
    logic new_stop;

    assign rx_byte = {shift_q[6:0], sda_i};
    assign addr_match = (rx_byte[7:1] == dev_addr_i) && (rx_byte[7:1] != 7'h00);
    assign hs_code = (rx_byte & ira_pkg::HS_CODE_MASK) == ira_pkg::HS_CODE_VAL;
    assign new_start = start_tgl_q != start_seen_q;
    assign new_stop = stop_tgl_q != stop_seen_q;

    // rising scl edge: sample data bits and the host acknowledge
    always_ff @(posedge scl_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            bit_q <= ira_pkg::BIT_CNT_RESET;
            shift_q <= 8'h00;
            ptr_q <= ira_pkg::PTR_RESET;
            ack_cycle_q <= 1'b0;
            ack_drive_q <= 1'b0;
            hs_tgl_q <= 1'b0;
            wr_tgl_q <= 1'b0;
            wr_data_q <= 8'h00;
            wr_addr_q <= 8'h00;
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
        end else if (new_start || new_stop) begin
            // first scl rise after a frame mark: restart byte framing
            start_seen_q <= start_tgl_q;
            stop_seen_q <= stop_tgl_q;
            state_q <= new_start ? ST_ADDR : ST_IDLE;
            shift_q <= {7'h00, sda_i};
            bit_q <= 3'h6;
            ack_cycle_q <= 1'b0;
            ack_drive_q <= 1'b0;
        end else if (ack_cycle_q) begin
            ack_cycle_q <= 1'b0;
            bit_q <= ira_pkg::BIT_CNT_RESET;
            if (state_q == ST_RACK) begin
                state_q <= sda_i ? ST_IDLE : ST_RDATA;
            end
        end else if (state_q == ST_RDATA) begin
            if (bit_q == 3'h0) begin
                ack_cycle_q <= 1'b1;
                state_q <= ST_RACK;
                ack_drive_q <= 1'b0;
                ptr_q <= ptr_q + 8'h01;
            end else begin
                bit_q <= bit_q - 3'h1;
            end
        end else if (state_q != ST_IDLE) begin
            shift_q <= rx_byte;
            if (bit_q == 3'h0) begin
                ack_cycle_q <= 1'b1;
                ack_drive_q <= 1'b0;
                case (state_q)
                    ST_ADDR: begin
                        if (addr_match) begin
                            ack_drive_q <= 1'b1;
                            state_q <= rx_byte[0] ? ST_RDATA : ST_PTR;
                        end else begin
                            if (hs_code) begin
                                hs_tgl_q <= ~hs_tgl_q;
                            end
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_PTR: begin
                        ptr_q <= rx_byte;
                        ack_drive_q <= 1'b1;
                        state_q <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        wr_data_q <= rx_byte;
                        wr_addr_q <= ptr_q;
                        wr_tgl_q <= ~wr_tgl_q;
                        ptr_q <= ptr_q + 8'h01;
                        ack_drive_q <= 1'b1;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end else begin
                bit_q <= bit_q - 3'h1;
            end
        end
    end

    // a written byte takes effect at the next sda rise, not at its own ack
    logic commit_tgl_q;
    always_ff @(posedge sda_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            commit_tgl_q <= 1'b0;
        end else begin
            commit_tgl_q <= wr_tgl_q;
        end
    end

    // register store; read data comes from the same array
    always_ff @(posedge scl_clk_i) begin
        if (state_q == ST_WDATA && bit_q == 3'h0 && !ack_cycle_q && !new_start && !new_stop) begin
            regs_q[ptr_q] <= rx_byte;
        end
    end

    // falling scl edge: present the next bit on sda
    always_ff @(negedge scl_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_en_q <= 1'b0;
            tx_bit_q <= 1'b1;
        end else if (ack_cycle_q) begin
            tx_en_q <= ack_drive_q;
            tx_bit_q <= 1'b0;
        end else if (state_q == ST_RDATA) begin
            tx_en_q <= 1'b1;
            tx_bit_q <= regs_q[ptr_q][bit_q];
        end else begin
            tx_en_q <= 1'b0;
            tx_bit_q <= 1'b1;
        end
    end

    // open drain: only a low is ever driven
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~(tx_en_q && !tx_bit_q);
    assign scl_o = 1'b0;
    assign scl_oe_n_o = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // crossings into the core domain
    logic hs_s;
    logic stop_s;
    logic wr_s;
    ira_sync u_hs_sync (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(hs_tgl_q), .q_o(hs_s));
    ira_sync u_stop_sync (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(stop_tgl_q), .q_o(stop_s));
    ira_sync u_wr_sync (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(commit_tgl_q), .q_o(wr_s));

    logic hs_prev_q;
    logic stop_prev_q;
    logic wr_prev_q;
    logic hs_q;
    logic commit_q;
    logic [7:0] out_data_q;
    logic [7:0] out_addr_q;
    logic [7:0] ptr_core_q;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hs_prev_q <= 1'b0;
            stop_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
            hs_q <= 1'b0;
            commit_q <= 1'b0;
            out_data_q <= 8'h00;
            out_addr_q <= 8'h00;
            ptr_core_q <= ira_pkg::PTR_RESET;
        end else if (clk_en_i) begin
            hs_prev_q <= hs_s;
            stop_prev_q <= stop_s;
            wr_prev_q <= wr_s;
            commit_q <= wr_s != wr_prev_q;
            ptr_core_q <= (stop_s != stop_prev_q) ? ptr_q : ptr_core_q;
            if (wr_s != wr_prev_q) begin
                out_data_q <= wr_data_q;
                out_addr_q <= wr_addr_q;
            end
            if (stop_s != stop_prev_q) begin
                hs_q <= 1'b0;
            end else if (hs_s != hs_prev_q) begin
                hs_q <= 1'b1;
            end
        end
    end
    assign hs_mode_o = hs_q;
    assign wr_commit_o = commit_q;
    assign wr_data_o = out_data_q;
    assign wr_addr_o = out_addr_q;
    assign reg_ptr_o = ptr_core_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence stop_seen_s;
        clk_en_i && (stop_s != stop_prev_q);
    endsequence
    scl_never_held_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        scl_oe_n_o) else $error("scl driven");
    stop_slow_filter_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        stop_seen_s |=> !hs_mode_o) else $error("hs kept after stop");
    write_commit_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_commit_o && clk_en_i |=> !wr_commit_o || $changed(wr_s))
        else $error("commit stuck");
    hs_enter_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i && (hs_s != hs_prev_q) && !(stop_s != stop_prev_q) |=> hs_mode_o)
        else $error("hs not entered");
    hs_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        hs_mode_o && !(stop_s != stop_prev_q) |=> hs_mode_o)
        else $error("hs dropped without stop");
    no_hs_ack_a: assert property (@(posedge scl_clk_i) disable iff (!rst_n_i)
        state_q == ST_ADDR && bit_q == 3'h0 && !ack_cycle_q && !new_start && !new_stop
        && !addr_match |=> !ack_drive_q) else $error("foreign address acked");
    ptr_ack_a: assert property (@(posedge scl_clk_i) disable iff (!rst_n_i)
        state_q == ST_PTR && bit_q == 3'h0 && !ack_cycle_q && !new_start && !new_stop
        |=> ack_drive_q && ack_cycle_q) else $error("pointer not acked");
    ptr_incr_a: assert property (@(posedge scl_clk_i) disable iff (!rst_n_i)
        state_q == ST_WDATA && bit_q == 3'h0 && !ack_cycle_q && !new_start && !new_stop
        |=> ptr_q == $past(ptr_q) + 8'h01) else $error("pointer not advanced");
    nack_release_a: assert property (@(negedge scl_clk_i) disable iff (!rst_n_i)
        state_q == ST_IDLE && !ack_cycle_q |=> sda_oe_n_o)
        else $error("sda held after nack");
endmodule
`default_nettype wire

/* File: bench/ira_host_model.sv */
// i2c bus controller model for the register access target
`timescale 1ns/100ps
`default_nettype none
module ira_host_model (
    // bus wires
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    ////////////////////////////////////////////////////////////////
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // scl stands high between frames; sda moves 4 ns after scl falls to avoid false start/stop
    task automatic start_c();
        #4 sda_o = 1'b1;
        #12 scl_o = 1'b1;
        #16 sda_o = 1'b0;
        #16 scl_o = 1'b0;
    endtask
    task automatic stop_c();
        #4 sda_o = 1'b0;
        #12 scl_o = 1'b1;
        #16 sda_o = 1'b1;
        #16;
    endtask
    // eight bits msb first, then the acknowledge slot driven with ack_i
    task automatic xfer(input logic [7:0] d_i, input logic ack_i, output logic [7:0] r_o,
                        output logic ack_o);
        logic [8:0] sh;
        sh = {d_i, ack_i};
        for (int i = 8; i >= 0; i--) begin
            #4 sda_o = sh[i];
            #12 scl_o = 1'b1;
            #8;
            if (i > 0) begin
                r_o[i-1] = sda_i;
            end else begin
                ack_o = sda_i;
            end
            #8 scl_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: bench/test_ira_slave.sv */
// self-checking bench for the i2c register access target
`timescale 1ns/100ps
`default_nettype none
module test_ira_slave;
    logic core_clk_i, rst_n_i, clk_en_i, m_scl, m_sda, sda_o, sda_oe_n_o, scl_o, scl_oe_n_o;
    logic hs_mode_o, wr_commit_o;
    logic [7:0] reg_ptr_o, wr_data_o, wr_addr_o;
    wire logic scl_w, sda_w;
    logic [15:0] cq[$];
    int n_mismatch = 0;
    int comparisons = 0;
    localparam logic [6:0] ADR = ira_pkg::DEV_ADDR_DEF;
    // pull-ups on both wires
    assign sda_w = m_sda & (sda_oe_n_o | sda_o);
    assign scl_w = m_scl & (scl_oe_n_o | scl_o);
    ////////////////////////////////////////////////////////////////
    ira_slave i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .scl_clk_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .dev_addr_i(ADR), .hs_mode_o(hs_mode_o),
        .reg_ptr_o(reg_ptr_o), .wr_data_o(wr_data_o), .wr_addr_o(wr_addr_o),
        .wr_commit_o(wr_commit_o));
    ira_host_model i_host (.scl_o(m_scl), .sda_o(m_sda), .sda_i(sda_w));
    always @(negedge core_clk_i) begin
        if (wr_commit_o === 1'b1) begin
            cq.push_back({wr_addr_o, wr_data_o});
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic put(input logic [7:0] d, input logic exp);
        logic [7:0] r;
        logic a;
        i_host.xfer(d, 1'b1, r, a);
        check("target ack", 8'(a), 8'(exp));
    endtask
    task automatic get(input logic [7:0] exp, input logic hack);
        logic [7:0] r;
        logic a;
        i_host.xfer(8'hff, hack, r, a);
        check("read data", r, exp);
    endtask
    task automatic commit_is(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] t;
        t = cq.size() > 0 ? cq.pop_front() : 16'hxxxx;
        check("commit", t[15:8], a);
        check("commit data", t[7:0], d);
    endtask
    // crossings are synchronised, so status is looked at a few core cycles later
    task automatic settle();
        repeat (8) @(negedge core_clk_i);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_write_seq();
        logic [7:0] r;
        logic a;
        i_host.start_c();
        put({ADR, 1'b0}, 1'b0);
        put(8'hfe, 1'b0);
        put(8'ha5, 1'b0);
        put(8'h5a, 1'b0);
        i_host.xfer(8'h3c, 1'b0, r, a); // host acks the last byte
        settle();
        check("commit before sda rise", 8'(cq.size()), 8'h02);
        i_host.stop_c();
        settle();
        commit_is(8'hfe, 8'ha5);
        commit_is(8'hff, 8'h5a);
        commit_is(8'h00, 8'h3c);
        check("pointer", reg_ptr_o, 8'h01);
    endtask
    task automatic t_read_seq();
        i_host.start_c();
        put({ADR, 1'b0}, 1'b0);
        put(8'hfe, 1'b0);
        i_host.start_c();
        put({ADR, 1'b1}, 1'b0);
        get(8'ha5, 1'b0);
        get(8'h5a, 1'b1);
        #2;
        check("sda released", 8'(sda_oe_n_o), 8'h01);
        i_host.stop_c();
        settle();
        i_host.start_c();
        put({ADR, 1'b1}, 1'b0);
        get(8'h3c, 1'b1);
        i_host.stop_c();
    endtask
    task automatic t_refuse();
        i_host.start_c();
        put(8'h00, 1'b1);
        i_host.stop_c();
        i_host.start_c();
        put({ADR ^ 7'h01, 1'b0}, 1'b1);
        i_host.stop_c();
        settle();
        check("stray commits", 8'(cq.size()), 8'h00);
    endtask
    task automatic t_hs(input logic [7:0] code);
        i_host.start_c();
        put(code, 1'b1);
        settle();
        check("fast filters", 8'(hs_mode_o), 8'h01);
        i_host.start_c();
        put({ADR, 1'b0}, 1'b0);
        put(8'h10, 1'b0);
        put(code, 1'b0);
        settle();
        check("fast after sr", 8'(hs_mode_o), 8'h01);
        i_host.stop_c();
        settle();
        check("slow after stop", 8'(hs_mode_o), 8'h00);
        commit_is(8'h10, code);
    endtask
    task automatic t_freeze();
        clk_en_i = 1'b0;
        i_host.start_c();
        put(8'h0c, 1'b1);
        settle();
        check("frozen filters", 8'(hs_mode_o), 8'h00);
        clk_en_i = 1'b1;
        settle();
        check("fast after enable", 8'(hs_mode_o), 8'h01);
        i_host.stop_c();
        settle();
        check("slow again", 8'(hs_mode_o), 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    initial begin
        rst_n_i = 1'b0;
        clk_en_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        settle();
        check("hs after reset", 8'(hs_mode_o), 8'h00);
        check("pointer after reset", reg_ptr_o, 8'h00);
        check("reset commits", 8'(cq.size()), 8'h00);
        t_write_seq();
        t_read_seq();
        t_refuse();
        t_hs(8'h08);
        t_hs(8'h0f);
        t_freeze();
        check("no stretch", 8'(scl_oe_n_o), 8'h01);
        check("drive level", 8'({sda_o, scl_o}), 8'h00);
        complete_run();
    end
    // whole run is eight frames of a few bytes; each byte takes about 0.3 us
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire
